// *** lane_cfg_if.sv ***
// carrier between the bank and one lane setup slot
`timescale 1ns/1ps
interface lane_cfg_if;
   import qcc_pkg::*;
   logic wr_en;
   byte_t wr_data;
   logic use_regs;
   logic off_in;
   byte_t pin_code;
   byte_t setup_q;
   byte_t eff_q;
   logic off_q;

   modport bank (output wr_en, wr_data, use_regs, off_in, pin_code, input setup_q, eff_q, off_q);
   modport slot (input wr_en, wr_data, use_regs, off_in, pin_code, output setup_q, eff_q, off_q);
endinterface : lane_cfg_if

// *** lane_cfg_slot.sv ***
// one lane setup register with its settings-source mux
`timescale 1ns/1ps
module lane_cfg_slot
   import qcc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // bank side
   lane_cfg_if.slot lane
);
   ////////////////////////////////////////////////////////////////
   // stored setup byte
   always_ff @(posedge clk) begin
      if (rst) begin
         lane.setup_q <= LANE_RESET;
      end else if (lane.wr_en) begin
         lane.setup_q <= lane.wr_data;
      end
   end

   ////////////////////////////////////////////////////////////////
   // applied settings: pins or register
   always_ff @(posedge clk) begin
      if (rst) begin
         lane.eff_q <= LANE_RESET;
      end else if (lane.use_regs) begin
         lane.eff_q <= lane.setup_q;
      end else begin
         lane.eff_q <= lane.pin_code;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lane.off_q <= 1'b0;
      end else begin
         lane.off_q <= lane.off_in;
      end
   end
endmodule : lane_cfg_slot

// *** qcc_chk.sv ***
// port assertions for the equalizer setup bank
`timescale 1ns/1ps
module qcc_chk
   import qcc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // byte stream
   input wire logic wr_byte_valid,
   input wire logic rd_byte_req,
   input wire logic rd_byte_valid,
   input wire qcc_pkg::byte_t target_addr,
   input wire logic target_addr_assigned,
   // lane settings
   input wire logic [3:0] lane1_peak_code,
   input wire logic [3:0] lane2_peak_code,
   input wire logic [3:0] lane3_peak_code,
   input wire logic [3:0] lane4_peak_code,
   input wire logic lane1_disable,
   input wire logic lane2_disable,
   input wire logic lane3_disable,
   input wire logic lane4_disable,
   input wire logic settings_source_select
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire [4:0] ctl = {settings_source_select, lane1_disable, lane2_disable, lane3_disable, lane4_disable};
   a_read_answer: assert property (rd_byte_req |=> rd_byte_valid)
      else $error("read answer missing");
   a_read_pulse: assert property (!rd_byte_req |=> !rd_byte_valid)
      else $error("read answer without request");
   a_pins_same: assert property (!settings_source_select && $past(!settings_source_select) |->
      lane1_peak_code == lane2_peak_code && lane3_peak_code == lane4_peak_code && lane1_peak_code == lane3_peak_code)
      else $error("lanes differ under pin control");
   a_addr_once: assert property (target_addr_assigned |=> $stable(target_addr))
      else $error("target address changed after assignment");
   a_assigned_sticks: assert property (target_addr_assigned |=> target_addr_assigned)
      else $error("address assignment lost");
   a_default_addr: assert property (!target_addr_assigned |-> target_addr == DEFAULT_TARGET_ADDR)
      else $error("default target address wrong");
   a_quiet_hold: assert property (!wr_byte_valid [*3] |=> $stable(ctl))
      else $error("control outputs moved without a write");
   a_reset_clear: assert property ($fell(rst) |-> ctl == 5'h00 && !target_addr_assigned && !rd_byte_valid)
      else $error("outputs not cleared by reset");
   c_source_regs: cover property ($rose(settings_source_select));
   c_addr_set: cover property ($rose(target_addr_assigned));
   c_read_done: cover property (rd_byte_valid);
endmodule : qcc_chk
bind quad_channel_config_regs qcc_chk qcc_chk_i (.*);

// *** qcc_host.sv ***
// bus host model feeding the byte stream
`timescale 1ns/1ps
module qcc_host
   import qcc_pkg::*;
(
   // clock
   input wire logic clk,
   // byte stream
   output logic frame_start,
   output logic frame_stop,
   output logic wr_byte_valid,
   output qcc_pkg::byte_t wr_byte,
   output logic rd_byte_req,
   input wire logic rd_byte_valid,
   input wire qcc_pkg::byte_t rd_byte
);
   initial begin
      {frame_start, frame_stop, wr_byte_valid, rd_byte_req, wr_byte} = '0;
   end
   task automatic wburst(input bit framed, input byte_t q[$]);
      @(negedge clk);
      frame_start = framed;
      @(negedge clk);
      frame_start = 1'b0;
      foreach (q[i]) begin
         wr_byte = q[i];
         wr_byte_valid = 1'b1;
         @(negedge clk);
      end
      wr_byte_valid = 1'b0;
      wr_byte = ~wr_byte;
      frame_stop = framed;
      @(negedge clk);
      frame_stop = 1'b0;
   endtask : wburst
   task automatic rbyte(output byte_t d, output logic v);
      @(negedge clk);
      rd_byte_req = 1'b1;
      @(negedge clk);
      rd_byte_req = 1'b0;
      v = rd_byte_valid;
      d = rd_byte;
   endtask : rbyte
endmodule : qcc_host

// *** qcc_pkg.sv ***
// shared constants for the four-lane equalizer setup bank
package qcc_pkg;
   typedef logic [7:0] byte_t;

   localparam int NUM_LANES = 4;
   localparam int SYNC_STAGES = 3;

   localparam byte_t OFS_RESERVED = 8'h00;
   localparam byte_t OFS_LANE_FIRST = 8'h01;
   localparam byte_t OFS_LANE_LAST = 8'h04;
   localparam byte_t OFS_CONTROL = 8'h05;
   localparam byte_t OFS_SPARE_FIRST = 8'h06;
   localparam byte_t OFS_SPARE_LAST = 8'h08;
   localparam byte_t OFS_TARGET_ADDR = 8'h3C;

   localparam byte_t LANE_RESET = 8'h00;
   localparam byte_t CONTROL_RESET = 8'h00;
   localparam byte_t RESERVED_READ = 8'h00;
   localparam byte_t UNMAPPED_READ = 8'h00;
   localparam byte_t DEFAULT_TARGET_ADDR = 8'hA2;
   localparam byte_t POINTER_RESET = 8'h00;

   localparam int PEAK_MSB = 7;
   localparam int PEAK_LSB = 4;
   localparam int GAIN_MSB = 3;
   localparam int GAIN_LSB = 2;
   localparam int SWING_MSB = 1;
   localparam int SWING_LSB = 0;
   localparam int SRC_SEL_BIT = 4;
   // lane one disable sits at bit 3, lane four at bit 0
   localparam int DISABLE_TOP_BIT = 3;

   typedef enum logic [2:0] {
      PH_IDLE = 3'b001,
      PH_POINTER = 3'b010,
      PH_DATA = 3'b100
   } frame_phase_e;
endpackage : qcc_pkg

// *** quad_channel_config_regs.sv ***
// setup register bank for a four-lane linear equalizer
//
// Overview of operation
// - bits 7:4 hold lane peaking code
// - bits 3:2 hold lane flat gain code
// - bits 1:0 hold lane output swing code
// - offset 0x02 is lane two setup
// - offset 0x03 is lane three, resets zero
// - offset 0x04 is lane four, resets zero
// - control bit 4 picks pins or registers
// - control bits 3..0 disable lanes one..four
// - first write byte loads pointer, autoincrement
// - unmapped writes dropped, checked per byte
// - offset 0x3C sets target bus address
`timescale 1ns/1ps
module quad_channel_config_regs
   import qcc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // byte stream from the serial target
   input wire logic frame_start,
   input wire logic frame_stop,
   input wire logic wr_byte_valid,
   input wire qcc_pkg::byte_t wr_byte,
   input wire logic rd_byte_req,
   output logic rd_byte_valid,
   output qcc_pkg::byte_t rd_byte,
   // target address
   output qcc_pkg::byte_t target_addr,
   output logic target_addr_assigned,
   // strap pins, asynchronous
   input wire logic [3:0] pin_peak_code,
   input wire logic [1:0] pin_gain_code,
   input wire logic [1:0] pin_swing_code,
   // applied lane settings
   output logic [3:0] lane1_peak_code,
   output logic [1:0] lane1_gain_code,
   output logic [1:0] lane1_swing_code,
   output logic lane1_disable,
   output logic [3:0] lane2_peak_code,
   output logic [1:0] lane2_gain_code,
   output logic [1:0] lane2_swing_code,
   output logic lane2_disable,
   output logic [3:0] lane3_peak_code,
   output logic [1:0] lane3_gain_code,
   output logic [1:0] lane3_swing_code,
   output logic lane3_disable,
   output logic [3:0] lane4_peak_code,
   output logic [1:0] lane4_gain_code,
   output logic [1:0] lane4_swing_code,
   output logic lane4_disable,
   output logic settings_source_select
);
   import qcc_pkg::*;

   frame_phase_e phase_q;
   byte_t pointer_q;
   byte_t control_q;
   byte_t target_addr_q;
   logic addr_taken_q;
   byte_t setup_view [NUM_LANES];
   logic rd_valid_q;
   byte_t rd_data_q;
   byte_t rd_data_d;
   logic data_wr;
   byte_t strap_s1_q;
   byte_t strap_s2_q;
   byte_t strap_s3_q;
   byte_t strap_q;

   lane_cfg_if lane_bus [NUM_LANES] ();

   ////////////////////////////////////////////////////////////////
   // frame phase and pointer
   assign data_wr = wr_byte_valid && (phase_q == PH_DATA);

   always_ff @(posedge clk) begin
      if (rst) begin
         phase_q <= PH_IDLE;
      end else if (frame_start) begin
         phase_q <= PH_POINTER;
      end else if (frame_stop) begin
         phase_q <= PH_IDLE;
      end else begin
         case (phase_q)
            PH_IDLE: phase_q <= PH_IDLE;
            PH_POINTER: begin
               if (wr_byte_valid) begin
                  phase_q <= PH_DATA;
               end
            end
            PH_DATA: phase_q <= PH_DATA;
            default: phase_q <= PH_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pointer_q <= POINTER_RESET;
      end else if (wr_byte_valid && (phase_q == PH_POINTER)) begin
         pointer_q <= wr_byte;
      end else if (data_wr || rd_byte_req) begin
         pointer_q <= pointer_q + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////
   // strap pin synchronisers
   always_ff @(posedge clk) begin
      if (rst) begin
         strap_s1_q <= LANE_RESET;
         strap_s2_q <= LANE_RESET;
         strap_s3_q <= LANE_RESET;
      end else begin
         strap_s1_q <= {pin_peak_code, pin_gain_code, pin_swing_code};
         strap_s2_q <= strap_s1_q;
         strap_s3_q <= strap_s2_q;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         strap_q <= LANE_RESET;
      end else if (strap_s2_q == strap_s3_q) begin
         strap_q <= strap_s3_q;
      end
   end

   ////////////////////////////////////////////////////////////////
   // shared control register
   always_ff @(posedge clk) begin
      if (rst) begin
         control_q <= CONTROL_RESET;
      end else if (data_wr && (pointer_q == OFS_CONTROL)) begin
         control_q <= wr_byte;
      end
   end

   ////////////////////////////////////////////////////////////////
   // target address, taken once
   always_ff @(posedge clk) begin
      if (rst) begin
         target_addr_q <= DEFAULT_TARGET_ADDR;
         addr_taken_q <= 1'b0;
      end else if (data_wr && (pointer_q == OFS_TARGET_ADDR) && !addr_taken_q) begin
         target_addr_q <= wr_byte;
         addr_taken_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////
   // lane slots
   for (genvar i = 0; i < NUM_LANES; i++) begin : g_lane
      assign lane_bus[i].wr_en = data_wr && (pointer_q == OFS_LANE_FIRST + 8'(i));
      // stored byte copied out, the read mux cannot index the slots
      assign setup_view[i] = lane_bus[i].setup_q;
      assign lane_bus[i].wr_data = wr_byte;
      assign lane_bus[i].use_regs = control_q[SRC_SEL_BIT];
      assign lane_bus[i].off_in = control_q[DISABLE_TOP_BIT - i];
      assign lane_bus[i].pin_code = strap_q;
      lane_cfg_slot u_slot (
         .clk(clk),
         .rst(rst),
         .lane(lane_bus[i])
      );
   end

   ////////////////////////////////////////////////////////////////
   // read data
   always_comb begin
      rd_data_d = UNMAPPED_READ;
      if (pointer_q >= OFS_LANE_FIRST && pointer_q <= OFS_LANE_LAST) begin
         rd_data_d = LANE_RESET;
         for (int k = 0; k < NUM_LANES; k++) begin
            if (pointer_q == OFS_LANE_FIRST + 8'(k)) begin
               rd_data_d = setup_view[k];
            end
         end
      end else if (pointer_q == OFS_CONTROL) begin
         rd_data_d = control_q;
      end else if (pointer_q == OFS_TARGET_ADDR) begin
         rd_data_d = target_addr_q;
      end else if (pointer_q == OFS_RESERVED) begin
         rd_data_d = RESERVED_READ;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data_q <= UNMAPPED_READ;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= rd_byte_req;
         if (rd_byte_req) begin
            rd_data_q <= rd_data_d;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // outputs
   assign rd_byte = rd_data_q;
   assign rd_byte_valid = rd_valid_q;
   assign target_addr = target_addr_q;
   assign target_addr_assigned = addr_taken_q;
   assign settings_source_select = control_q[SRC_SEL_BIT];

   assign lane1_peak_code = lane_bus[0].eff_q[PEAK_MSB:PEAK_LSB];
   assign lane2_peak_code = lane_bus[1].eff_q[PEAK_MSB:PEAK_LSB];
   assign lane3_peak_code = lane_bus[2].eff_q[PEAK_MSB:PEAK_LSB];
   assign lane4_peak_code = lane_bus[3].eff_q[PEAK_MSB:PEAK_LSB];
   assign lane1_gain_code = lane_bus[0].eff_q[GAIN_MSB:GAIN_LSB];
   assign lane2_gain_code = lane_bus[1].eff_q[GAIN_MSB:GAIN_LSB];
   assign lane3_gain_code = lane_bus[2].eff_q[GAIN_MSB:GAIN_LSB];
   assign lane4_gain_code = lane_bus[3].eff_q[GAIN_MSB:GAIN_LSB];
   assign lane1_swing_code = lane_bus[0].eff_q[SWING_MSB:SWING_LSB];
   assign lane2_swing_code = lane_bus[1].eff_q[SWING_MSB:SWING_LSB];
   assign lane3_swing_code = lane_bus[2].eff_q[SWING_MSB:SWING_LSB];
   assign lane4_swing_code = lane_bus[3].eff_q[SWING_MSB:SWING_LSB];
   assign lane1_disable = lane_bus[0].off_q;
   assign lane2_disable = lane_bus[1].off_q;
   assign lane3_disable = lane_bus[2].off_q;
   assign lane4_disable = lane_bus[3].off_q;
endmodule : quad_channel_config_regs

// *** test_quad_channel_config_regs.sv ***
// self-checking bench for the equalizer setup bank
`timescale 1ns/1ps
module test_quad_channel_config_regs;
   import qcc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic frame_start, frame_stop, wr_byte_valid, rd_byte_req, rd_byte_valid, target_addr_assigned;
   logic settings_source_select, lane1_disable, lane2_disable, lane3_disable, lane4_disable, v;
   byte_t wr_byte, rd_byte, target_addr, d, first_addr;
   logic [3:0] pin_peak_code, lane1_peak_code, lane2_peak_code, lane3_peak_code, lane4_peak_code;
   logic [1:0] pin_gain_code, lane1_gain_code, lane2_gain_code, lane3_gain_code, lane4_gain_code;
   logic [1:0] pin_swing_code, lane1_swing_code, lane2_swing_code, lane3_swing_code, lane4_swing_code;
   int err_total = 0;
   int compares = 0;
   int seed = 32'h01a1;
   int ptr;
   bit assigned;
   byte_t mem[0:5];
   byte_t q[$];
   wire [7:0] lane_v [4];
   wire [3:0] dis = {lane1_disable, lane2_disable, lane3_disable, lane4_disable};
   assign lane_v[0] = {lane1_peak_code, lane1_gain_code, lane1_swing_code};
   assign lane_v[1] = {lane2_peak_code, lane2_gain_code, lane2_swing_code};
   assign lane_v[2] = {lane3_peak_code, lane3_gain_code, lane3_swing_code};
   assign lane_v[3] = {lane4_peak_code, lane4_gain_code, lane4_swing_code};
   always #12.5 clk = ~clk;
   quad_channel_config_regs quad_channel_config_regs_i (.*);
   qcc_host qcc_host_i (.*);
   ////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic complete_run;
      if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   task automatic do_reset;
      rst = 1'b1;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      mem = '{default: 8'h00};
      ptr = 0;
      assigned = 1'b0;
   endtask : do_reset
   // model of the write path
   task automatic wr(input bit framed, input byte_t b[$]);
      qcc_host_i.wburst(framed, b);
      if (framed) begin
         ptr = b[0];
         for (int i = 1; i < b.size(); i++) begin
            if (ptr >= 1 && ptr <= 5) mem[ptr] = b[i];
            if (ptr == 8'h3C && !assigned) first_addr = b[i];
            if (ptr == 8'h3C) assigned = 1'b1;
            ptr = (ptr + 1) % 256;
         end
      end
   endtask : wr
   task automatic chk_all;
      repeat (8) @(negedge clk);
      for (int i = 0; i < 4; i++) begin
         check("lane", lane_v[i], mem[5][4] ? mem[i + 1] : {pin_peak_code, pin_gain_code, pin_swing_code});
      end
      check("disable", dis, mem[5][3:0]);
      check("source", settings_source_select, mem[5][4]);
      check("addr", target_addr, assigned ? first_addr : 8'hA2);
      check("assigned", target_addr_assigned, assigned);
   endtask : chk_all
   ////////////////////////////////////////////////////////////////
   initial begin
      #(25ns * 4000);
      err_total++;
      complete_run();
   end
   initial begin
      {pin_peak_code, pin_gain_code, pin_swing_code} = 8'($random(seed));
      do_reset();
      chk_all();
      repeat (3) begin
         {pin_peak_code, pin_gain_code, pin_swing_code} = 8'($random(seed));
         chk_all();
      end
      q = {8'h00};
      repeat (9) q.push_back(byte_t'($random(seed)));
      q[6] = q[6] | 8'h10;
      wr(1'b1, q);
      chk_all();
      wr(1'b1, {8'h00});
      for (int a = 0; a < 9; a++) begin
         qcc_host_i.rbyte(d, v);
         check("valid", v, 8'h01);
         check("read", d, (ptr >= 1 && ptr <= 5) ? mem[ptr] : 8'h00);
         ptr++;
      end
      for (int i = 0; i < 4; i++) begin
         wr(1'b1, {8'h05, byte_t'(8'h10 | (1 << i))});
         chk_all();
      end
      wr(1'b0, {8'h01, 8'h5A});
      chk_all();
      wr(1'b1, {8'h3C, 8'h10});
      wr(1'b1, {8'h3C, 8'h20});
      chk_all();
      wr(1'b1, {8'hFF, 8'hC3, 8'h3A, 8'h05, 8'h1F});
      chk_all();
      do_reset();
      chk_all();
      complete_run();
   end
endmodule : test_quad_channel_config_regs
